// File: core/resp_sequencer.sv
/*
 Forwarder and governor pulse timer for remote engine speed control.
 Assumes frames arrive decoded from a 250 kbaud controller on this clock,
 and that speed limits and step sizes are stable configuration inputs.
 MS_CYC sets the millisecond tick; a shorter tick only compresses time.
*/
`timescale 1ns/1ps
module resp_sequencer
	import resp_pkg::*;
#(
	parameter int SPD_W  = 16,          // Engine speed width
	parameter int MS_CYC = MS_TICK_CYC  // Clock cycles per millisecond tick
) (
	input  wire logic              clk,
	input  wire logic              rst_n,
	input  wire logic              rx_valid,
	input  wire resp_frame_t       rx_frame,
	output logic                   tx_valid,
	output resp_frame_t            tx_frame,
	input  wire logic [SPD_W-1:0]  spd_min,
	input  wire logic [SPD_W-1:0]  spd_max,
	input  wire logic [SPD_W-1:0]  spd_step,
	input  wire logic [SPD_W-1:0]  spd_ramp,
	output logic                   gov_active,
	output logic [SPD_W-1:0]       spd_target,
	output logic                   seq_error
);
	// Divider width and terminal count; MS_CYC must be at least two
	localparam int               DIV_W    = $clog2(MS_CYC);
	localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(MS_CYC - 1);

	logic [DIV_W-1:0] div_q;      // Millisecond divider
	logic             ms_tick;    // One-cycle millisecond enable
	logic [15:0]      lead_q;     // Time since enable went on, not counting presses
	logic [15:0]      hold_q;     // Time current press has lasted
	logic [15:0]      ramp_q;     // Ramp interval counter
	logic             var_q;      // Latched enable switch
	logic             res_q;      // Latched resume switch
	logic             set_q;      // Latched set switch
	logic             prs_q;      // Press seen on the previous cycle
	logic             dir_q;      // Direction of the current press, 1 for resume
	resp_state_t      st_q;       // Governor state
	resp_state_t      st_d;       // Next governor state
	logic [SPD_W-1:0] spd_q;      // Commanded speed
	logic [SPD_W-1:0] spd_d;      // Next commanded speed
	logic             err_q;      // Both switches seen on together
	resp_frame_t      fwd_frame;  // Frame as it leaves on the powertrain side

	// Clamp a value into the configured window
	function automatic logic [SPD_W-1:0] clamp(input logic [SPD_W:0] v);
		if (v > {1'b0, spd_max})
			clamp = spd_max;
		else if (v < {1'b0, spd_min})
			clamp = spd_min;
		else
			clamp = v[SPD_W-1:0];
	endfunction

	// Raise by an amount; the spare top bit keeps a carry from wrapping
	function automatic logic [SPD_W-1:0] step_up(input logic [SPD_W-1:0] cur,
	                                             input logic [SPD_W-1:0] amt);
		step_up = clamp({1'b0, cur} + {1'b0, amt});
	endfunction

	// Lower by an amount; a borrow would wrap to a huge value, so it
	// lands on the minimum instead of being clamped to the maximum
	function automatic logic [SPD_W-1:0] step_dn(input logic [SPD_W-1:0] cur,
	                                             input logic [SPD_W-1:0] amt);
		if (cur < amt)
			step_dn = spd_min;
		else
			step_dn = clamp({1'b0, cur - amt});
	endfunction

	// Saturating millisecond counter step, so a long hold never wraps
	function automatic logic [15:0] sat_inc(input logic [15:0] c);
		sat_inc = (c == MS_CNT_MAX) ? c : c + 16'h0001;
	endfunction

	// Frame qualification and switch decoding
	wire from_remote = rx_valid && (rx_frame.src == SA_REMOTE);
	wire var_on      = (rx_frame.var_sw == SW_ON);
	wire res_on      = (rx_frame.res_sw == SW_ON);
	wire set_on      = (rx_frame.set_sw == SW_ON);
	// Press tracking: exactly one of resume or set, enable on
	wire both_on     = res_q && set_q;
	wire pressed     = (res_q ^ set_q) && var_q;
	wire released    = prs_q && !pressed;
	// A press counts as a step only inside the width window
	wire pulse_ok    = released && (hold_q > 16'(PULSE_MIN_MS))
	                   && (hold_q < 16'(PULSE_MAX_MS));
	wire lead_ok     = (lead_q >= 16'(LEAD_MS));
	// A press longer than the window turns into a ramp
	wire ramping     = pressed && (hold_q >= 16'(PULSE_MAX_MS));
	wire ramp_due    = ramping && ms_tick && (ramp_q == 16'(RAMP_MS - 1));
	assign ms_tick   = (div_q == DIV_LAST);

	// Forwarded copy keeps the switches, swaps the source address
	assign fwd_frame = '{src:    SA_FORWARD,
	                     var_sw: rx_frame.var_sw,
	                     res_sw: rx_frame.res_sw,
	                     set_sw: rx_frame.set_sw};

	// Millisecond time base
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			div_q <= '0;
		else
			div_q <= ms_tick ? '0 : div_q + 1'b1;
	end

	// Pass remote frames through under the forwarding address
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_valid <= 1'b0;
			tx_frame <= '0;
		end else begin
			tx_valid <= from_remote;
			// Frame holds until the next forwarded frame
			if (from_remote)
				tx_frame <= fwd_frame;
		end
	end

	// Latch switch states from each remote frame
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			var_q <= 1'b0;
			res_q <= 1'b0;
			set_q <= 1'b0;
		end else if (from_remote) begin
			var_q <= var_on;
			res_q <= res_on;
			set_q <= set_on;
		end
	end

	// Lead, press and ramp timers in milliseconds
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			lead_q <= '0;
			hold_q <= '0;
			ramp_q <= '0;
			prs_q  <= 1'b0;
			dir_q  <= 1'b0;
		end else begin
			prs_q <= pressed;
			// Direction is kept past the release, which is when it is used
			if (pressed)
				dir_q <= res_q;
			// Lead time freezes during a press and restarts with the enable
			if (!var_q)
				lead_q <= '0;
			else if (ms_tick && !prs_q)
				lead_q <= sat_inc(lead_q);
			// Press width in whole milliseconds
			if (!pressed)
				hold_q <= '0;
			else if (ms_tick)
				hold_q <= sat_inc(hold_q);
			// Ramp interval restarts each step and whenever no ramp runs
			if (!ramping || ramp_due)
				ramp_q <= '0;
			else if (ms_tick)
				ramp_q <= ramp_q + 16'h0001;
		end
	end

	// Next state and speed of the governor
	always_comb begin
		st_d  = st_q;
		spd_d = spd_q;
		case (st_q)
			// Waiting for the enable switch
			RESP_IDLE: begin
				if (var_q)
					st_d = RESP_ARMED;
			end
			// Enable on; only a timed pulse after the lead starts the governor
			RESP_ARMED: begin
				if (!var_q)
					st_d = RESP_IDLE;
				else if (pulse_ok && lead_ok) begin
					st_d  = RESP_ACTIVE;
					spd_d = spd_min;
				end
			end
			// Governing: pulses step, long holds ramp, enable off leaves
			RESP_ACTIVE: begin
				if (!var_q)
					st_d = RESP_IDLE;
				// Steps take effect at release, in the direction pressed
				else if (pulse_ok && dir_q)
					spd_d = step_up(spd_q, spd_step);
				else if (pulse_ok && !dir_q)
					spd_d = step_dn(spd_q, spd_step);
				// Held switch moves the speed once per ramp interval
				else if (ramp_due && res_q)
					spd_d = step_up(spd_q, spd_ramp);
				else if (ramp_due)
					spd_d = step_dn(spd_q, spd_ramp);
			end
			// Unused code falls back to idle
			default: st_d = RESP_IDLE;
		endcase
		// Conflicting switches freeze the speed whatever the state wants
		if (both_on)
			spd_d = spd_q;
	end

	// Governor registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q  <= RESP_IDLE;
			spd_q <= '0;
			err_q <= 1'b0;
		end else begin
			st_q  <= st_d;
			spd_q <= spd_d;
			err_q <= both_on;
		end
	end

	// Outputs come from registers, gov_active through a compare on the state register
	assign gov_active = (st_q == RESP_ACTIVE);
	assign spd_target = spd_q;
	assign seq_error  = err_q;
endmodule

// File: shared/resp_pkg.sv
/*
 Constants and types for the remote engine speed pulse sequencer.
 Assumes one 10 MHz clock and CAN frames already decoded into switch fields.
*/
// How it works
// - Remote link runs at 250 kbaud
// - Body controller passes remote frames through
// - Governor starts only on timed pulse
// - Speed kept between minimum and maximum by each step and ramp; reset loads zero
// - Retransmit on powertrain from address 0x21
package resp_pkg;
	localparam int          CLK_HZ         = 10_000_000;  // System clock rate
	localparam int          LINK_BAUD      = 250_000;     // Body builder link rate
	localparam logic [7:0]  SA_REMOTE      = 8'h07;       // Remote module address
	localparam logic [7:0]  SA_FORWARD     = 8'h21;       // Forwarding address
	localparam int          MS_TICK_CYC    = CLK_HZ / 1000;  // Cycles per millisecond
	localparam int          PULSE_MIN_MS   = 100;         // Valid pulse must last longer than this
	localparam int          PULSE_MAX_MS   = 500;         // Valid pulse must end before this
	localparam int          LEAD_MS        = 100;         // Enable-to-pulse lead
	localparam int          RAMP_MS        = 10;          // Ramp update period
	localparam logic [1:0]  SW_OFF         = 2'b00;       // Switch field off
	localparam logic [1:0]  SW_ON          = 2'b01;       // Switch field on
	localparam logic [15:0] MS_CNT_MAX     = 16'hFFFF;    // Millisecond counter ceiling

	// Decoded switch fields of one frame
	typedef struct packed {
		logic [7:0] src;      // Source address
		logic [1:0] var_sw;   // Variable speed switch
		logic [1:0] res_sw;   // Resume switch
		logic [1:0] set_sw;   // Set switch
	} resp_frame_t;

	// Governor states
	typedef enum logic [1:0] {
		RESP_IDLE,
		RESP_ARMED,
		RESP_ACTIVE
	} resp_state_t;
endpackage

// File: test/resp_chk.sv
/* Port assertions for the sequencer.
 Assumes one clock and the async active-low reset. */
`timescale 1ns/1ps
module resp_chk
	import resp_pkg::*;
#(
	parameter int SPD_W = 16  // Speed width
) (
	input wire logic             clk,
	input wire logic             rst_n,
	input wire logic             rx_valid,
	input wire resp_frame_t      rx_frame,
	input wire logic             tx_valid,
	input wire resp_frame_t      tx_frame,
	input wire logic [SPD_W-1:0] spd_min,
	input wire logic [SPD_W-1:0] spd_max,
	input wire logic             gov_active,
	input wire logic [SPD_W-1:0] spd_target,
	input wire logic             seq_error
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// Frame taken from the remote address
	sequence take_s;
		rx_valid && rx_frame.src == SA_REMOTE;
	endsequence
	fwd_lat_a: assert property (take_s |=> tx_valid)
		else $error("remote frame not forwarded");
	fwd_none_a: assert property (!(rx_valid && rx_frame.src == SA_REMOTE) |=> !tx_valid)
		else $error("frame forwarded without cause");
	fwd_src_a: assert property (tx_valid |-> tx_frame.src == SA_FORWARD)
		else $error("forwarded source wrong");
	fwd_data_a: assert property (take_s ##1 tx_valid |-> tx_frame[5:0] == $past(rx_frame[5:0]))
		else $error("forwarded switches differ");
	gov_start_a: assert property ($rose(gov_active) |-> spd_target == spd_min)
		else $error("governor start speed wrong");
	spd_range_a: assert property (gov_active |-> spd_target >= spd_min && spd_target <= spd_max)
		else $error("speed outside limits");
	both_hold_a: assert property (seq_error ##1 seq_error |-> $stable(spd_target))
		else $error("speed moved while both pressed");
	// Remote frame with the enable off
	sequence var_off_s;
		take_s ##0 rx_frame.var_sw != SW_ON;
	endsequence
	gov_idle_a: assert property (var_off_s |=> ##1 !gov_active)
		else $error("governor kept after enable off");
endmodule

// File: test/resp_remote.sv
/* Remote module model: one switch frame per period.
 Assumes the bench sets the levels at the falling edge. */
`timescale 1ns/1ps
module resp_remote
	import resp_pkg::*;
#(
	parameter int PER = 10000  // Cycles between frames
) (
	input wire logic       clk,
	input wire logic [7:0] src,
	input wire logic       var_on,
	input wire logic       res_on,
	input wire logic       set_on,
	output logic           rx_valid,
	output resp_frame_t    rx_frame
);
	int cnt = 0;  // Period counter
	initial rx_valid = 0;
	initial rx_frame = '0;
	// Send each period; lines toggle between frames
	always @(negedge clk) begin
		cnt = (cnt == PER - 1) ? 0 : cnt + 1;
		rx_valid <= (cnt == 0);
		rx_frame <= (cnt == 0) ? {src, 1'b0, var_on, 1'b0, res_on, 1'b0, set_on} : ~rx_frame;
	end
endmodule

// File: test/tb.sv
/* Top bench: remote model drives the sequencer.
 Assumes package, design, model and checker compiled first. */
`timescale 1ns/1ps
module tb import resp_pkg::*;;
	logic clk = 0, rst_n = 0, var_on = 0, res_on = 0, set_on = 0;
	logic [7:0] src = SA_REMOTE;
	logic rx_valid, tx_valid, gov_active, seq_error;
	resp_frame_t rx_frame, tx_frame, q[$];
	logic [15:0] spd_target, mn = 16'h0100, mx = 16'h0300, st = 16'h0100, rp = 16'h0040;
	localparam int TB_MS = 20;  // Shortened millisecond keeps the run short
	localparam int TB_PER = 4;  // Cycles between remote frames
	int mismatches = 0, n_tests = 0, cyc = 0, seed = 32'h4519_7b28;
	initial forever #50 clk = ~clk;
	resp_remote #(.PER(TB_PER)) i_resp_remote(.clk, .src, .var_on, .res_on, .set_on,
		.rx_valid, .rx_frame);
	resp_sequencer #(.MS_CYC(TB_MS)) i_resp_sequencer(.clk, .rst_n, .rx_valid, .rx_frame,
		.tx_valid, .tx_frame, .spd_min(mn), .spd_max(mx), .spd_step(st), .spd_ramp(rp),
		.gov_active, .spd_target, .seq_error);
	task automatic check(string nm, logic [15:0] got, logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic wait_ms(int n);
		repeat (n * TB_MS) @(negedge clk);
	endtask
	// Press resume or set n ms, release, then check speed
	task automatic press(logic r, logic s, int n, logic [15:0] exp);
		res_on = r;
		set_on = s;
		wait_ms(n);
		res_on = 0;
		set_on = 0;
		wait_ms(5);
		check("spd_target", spd_target, exp);
	endtask
	// Note each remote frame; compare on each forward
	always @(posedge clk) if (rst_n && rx_valid && rx_frame.src == SA_REMOTE)
		q.push_back({SA_FORWARD, rx_frame[5:0]});
	always @(negedge clk) if (tx_valid)
		check("tx_frame", tx_frame, q.size() ? q.pop_front() : 16'hxxxx);
	// Hang guard
	always @(posedge clk) begin
		cyc++;
		if (cyc == 60_000) begin
			mismatches++;
			finish_test();
		end
	end
	initial begin
		repeat (16) @(negedge clk);
		rst_n = 1;
		for (int i = 0; i < 8; i++) begin
			src = ($random(seed) & 1) ? SA_REMOTE : 8'($random(seed));
			var_on = 1'($random(seed));
			wait_ms(1);
		end
		src = SA_REMOTE;
		var_on = 0;
		wait_ms(2);
		check("gov_active", gov_active, 0);
		var_on = 1;
		// Pulse too soon after enable must not start the governor
		wait_ms(20);
		press(1, 0, 120, 0);
		check("gov_active", gov_active, 0);
		wait_ms(85);
		press(1, 0, 120, mn);
		check("gov_active", gov_active, 1);
		press(1, 0, 120, mn + st);
		press(0, 1, 120, mn);
		press(0, 1, 120, mn);
		press(1, 0, 50, mn);
		res_on = 1;
		set_on = 1;
		wait_ms(20);
		check("seq_error", seq_error, 1);
		check("spd_target", spd_target, mn);
		res_on = 0;
		set_on = 0;
		wait_ms(5);
		check("seq_error", seq_error, 0);
		// Long hold: no move inside the width window, then a ramp
		res_on = 1;
		wait_ms(400);
		check("spd_target", spd_target, mn);
		wait_ms(300);
		res_on = 0;
		wait_ms(5);
		check("spd_target", spd_target, mx);
		press(0, 1, 700, mn);
		// Foreign source stops new notes so the queue can drain
		src = 8'h00;
		wait_ms(1);
		check("q_left", q.size(), 0);
		finish_test();
	end
endmodule
bind resp_sequencer resp_chk #(.SPD_W(SPD_W)) i_resp_chk(.clk, .rst_n, .rx_valid, .rx_frame,
	.tx_valid, .tx_frame, .spd_min, .spd_max, .gov_active, .spd_target, .seq_error);
